// ---- src/hbf_fault_status.sv ----
// fault, status and sleep logic of the ten-channel half-bridge driver
// What this block does
// - readback bit: 1 high-side on, 0 low-side on
// - heat warning follows junction warning level
// - heat warning alone never turns outputs off
// - enable low: sleep, outputs off, registers reset
// - enable high: leave sleep, outputs drive after next command
// - status clear acts only after frame ends
// - status clear acts on selected group only
// - persisting fault is detected again after clear
// - enable toggle or power-on also clears faults
// - open-load check on low side, only when on
// - low current beyond delay sets fault bit
// - one shared timer; late channels use remainder
// - shared timer keeps running while under-load persists
// - armed cutoff: output off, error latched
// - cutoff not armed: error set, output stays
// - error and cutoff held until clear or reset
// - group select scopes cutoff arm and clear
// - low-side braking flags under-load in bit 13
// - discharge path on while supply above threshold
// - group bit latches any under-load fault on bridges 7-10
`timescale 1ns/1ps
`default_nettype none

module hbf_fault_status
  import hbf_pkg::*;
#(
  parameter int UL_DELAY = HBF_UL_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic spiSelect_n,
  input wire logic mosi,
  output logic miso,
  input wire logic enablePin,
  input wire logic heatWarnPin,
  input wire logic [1:0] heatShutPin,
  input wire logic supplyOverDischarge,
  input wire logic [HBF_CHANNELS-1:0] lsUnderCurrent,
  output logic [HBF_CHANNELS-1:0] hsOn,
  output logic [HBF_CHANNELS-1:0] lsOn,
  output logic dischargeOn,
  output logic sleepMode
);

  localparam int TMR_W = $clog2(UL_DELAY + 1);
  localparam logic [TMR_W-1:0] UL_LAST = TMR_W'(UL_DELAY - 1);
  localparam logic [TMR_W-1:0] UL_ONE = TMR_W'(1);
  localparam logic [TMR_W-1:0] UL_ZERO = TMR_W'(0);
  localparam int SYNC_W = HBF_CHANNELS + 7;

  // channels of a group as a ten-bit mask
  function automatic logic [9:0] groupMask(input logic sel);
    groupMask = sel ? HBF_GROUP1_MASK : HBF_GROUP0_MASK;
  endfunction

  // place group bits onto the channels of that group (six for lower group, low four for upper group)
  function automatic logic [9:0] placeGroup(input logic sel, input logic [5:0] bits);
    placeGroup = sel ? {bits[3:0], 6'h00} : {4'h0, bits};
  endfunction

  // serial link domain
  logic [3:0] bitCnt;
  logic [HBF_FRAME_BITS-2:0] rxShift;
  hbf_cmd_type rxWord;
  logic frameTgl;
  hbf_status_type statusSnap;

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt <= 4'h0;
    end else if (!spiSelect_n) begin
      bitCnt <= bitCnt + 4'h1;
    end
  end

  // full word is handed over with a toggle on the last bit
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rxShift <= 15'h0000;
      rxWord <= hbf_cmd_type'(16'h0000);
      frameTgl <= 1'b0;
    end else if (!spiSelect_n) begin
      rxShift <= {rxShift[HBF_FRAME_BITS-3:0], mosi};
      if (bitCnt == HBF_FRAME_LAST) begin
        rxWord <= hbf_cmd_type'({rxShift, mosi});
        frameTgl <= ~frameTgl;
      end
    end
  end

  // status shifts out msb first; snapshot is frozen while selected
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      miso <= 1'b0;
    end else if (!spiSelect_n) begin
      miso <= statusSnap[HBF_FRAME_LAST - bitCnt];
    end
  end

  // pin and cross-domain synchronisers
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {frameTgl, spiSelect_n, enablePin, heatWarnPin, heatShutPin,
                supplyOverDischarge, lsUnderCurrent};
      syncB <= syncA;
    end
  end

  logic tglSync;
  logic csHigh;
  logic enSync;
  logic warnSync;
  logic [1:0] shutSync;
  logic dischSync;
  logic [HBF_CHANNELS-1:0] underSync;

  assign {tglSync, csHigh, enSync, warnSync, shutSync, dischSync, underSync} = syncB;

  // sleep and run
  hbf_mode_type mode;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= HBF_SLEEP;
    end else begin
      case (mode)
        HBF_SLEEP: mode <= enSync ? HBF_RUN : HBF_SLEEP;
        HBF_RUN: mode <= enSync ? HBF_RUN : HBF_SLEEP;
        default: mode <= HBF_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleepMode <= 1'b1;
    end else begin
      sleepMode <= !enSync;
    end
  end

  // command intake in the core domain
  logic tglSeen;
  logic cmdPending;
  logic cmdExec;
  logic clearPulse;
  logic clearGroup;

  assign cmdExec = cmdPending && csHigh;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tglSeen <= 1'b0;
      cmdPending <= 1'b0;
    end else begin
      tglSeen <= tglSync;
      if (tglSync != tglSeen) begin
        cmdPending <= 1'b1;
      end else if (cmdExec) begin
        cmdPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clearPulse <= 1'b0;
      clearGroup <= 1'b0;
    end else begin
      clearPulse <= cmdExec && enSync && rxWord.statusClear;
      if (cmdExec) begin
        clearGroup <= rxWord.channelGroupSelect;
      end
    end
  end

  logic [9:0] clrMask;

  assign clrMask = clearPulse ? groupMask(clearGroup) : HBF_ALL_CLEAR;

  // drive settings and cutoff arm, one group per command
  logic [9:0] drvEn;
  logic [9:0] drvCfg;
  logic [9:0] cutArm;
  logic [9:0] cmdMask;

  assign cmdMask = groupMask(rxWord.channelGroupSelect);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drvEn <= HBF_ALL_CLEAR;
      drvCfg <= HBF_ALL_CLEAR;
      cutArm <= HBF_ALL_CLEAR;
    end else if (!enSync) begin
      drvEn <= HBF_ALL_CLEAR;
      drvCfg <= HBF_ALL_CLEAR;
      cutArm <= HBF_ALL_CLEAR;
    end else if (cmdExec) begin
      drvEn <= (drvEn & ~cmdMask)
               | placeGroup(rxWord.channelGroupSelect, rxWord.bridgeEnable);
      drvCfg <= (drvCfg & ~cmdMask)
                | placeGroup(rxWord.channelGroupSelect, rxWord.bridgeConfig);
      cutArm <= (cutArm & ~cmdMask) | (cmdMask & {10{rxWord.underloadCutoffArm}});
    end
  end

  // shared open-load qualify timer
  logic [TMR_W-1:0] ulTimer;
  logic [9:0] ulEligible;
  logic anyUl;
  logic ulExpire;

  assign ulEligible = (mode == HBF_RUN) ? (lsOn & underSync) : HBF_ALL_CLEAR;
  assign anyUl = |ulEligible;
  assign ulExpire = anyUl && (ulTimer == UL_LAST);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ulTimer <= UL_ZERO;
    end else if (!anyUl || ulExpire) begin
      ulTimer <= UL_ZERO;
    end else begin
      ulTimer <= ulTimer + UL_ONE;
    end
  end

  // latched faults; a new detection wins over a clear
  logic [9:0] ulFault;
  logic [9:0] ulCutoff;
  logic [1:0] heatLatch;
  logic [9:0] heatBlock;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ulFault <= HBF_ALL_CLEAR;
      ulCutoff <= HBF_ALL_CLEAR;
    end else if (!enSync) begin
      ulFault <= HBF_ALL_CLEAR;
      ulCutoff <= HBF_ALL_CLEAR;
    end else begin
      ulFault <= (ulFault & ~clrMask) | (ulExpire ? ulEligible : HBF_ALL_CLEAR);
      ulCutoff <= (ulCutoff & ~clrMask)
                  | (ulExpire ? (ulEligible & cutArm) : HBF_ALL_CLEAR);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      heatLatch <= HBF_HEAT_CLEAR;
    end else if (!enSync) begin
      heatLatch <= HBF_HEAT_CLEAR;
    end else begin
      heatLatch <= (heatLatch & ~{clrMask[HBF_UPPER_BASE], clrMask[0]}) | shutSync;
    end
  end

  assign heatBlock = {{HBF_UPPER_COUNT{heatLatch[1]}}, {HBF_GROUP_WIDTH{heatLatch[0]}}};

  // output stages; heat warning does not gate them
  logic [9:0] active;

  assign active = (mode == HBF_RUN) ? (drvEn & ~ulCutoff & ~heatBlock) : HBF_ALL_CLEAR;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hsOn <= HBF_ALL_CLEAR;
      lsOn <= HBF_ALL_CLEAR;
    end else if (!enSync) begin
      hsOn <= HBF_ALL_CLEAR;
      lsOn <= HBF_ALL_CLEAR;
    end else begin
      hsOn <= active & drvCfg;
      lsOn <= active & ~drvCfg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dischargeOn <= 1'b0;
    end else begin
      dischargeOn <= dischSync;
    end
  end

  // status word, frozen while a frame is in progress
  hbf_status_type statusNow;
  logic [3:0] upperHs;
  logic [3:0] upperLs;

  assign upperHs = hsOn[HBF_CHANNELS-1:HBF_UPPER_BASE];
  assign upperLs = lsOn[HBF_CHANNELS-1:HBF_UPPER_BASE];

  always_comb begin
    statusNow = hbf_status_type'(HBF_STATUS_RESET);
    statusNow.heatWarningFlag = warnSync;
    statusNow.configReadback = upperHs & ~upperLs;
    statusNow.bridgeActive = upperHs | upperLs;
    statusNow.underloadFaultFlag = |ulFault[HBF_CHANNELS-1:HBF_UPPER_BASE];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusSnap <= hbf_status_type'(HBF_STATUS_RESET);
    end else if (csHigh) begin
      statusSnap <= statusNow;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_sleep_outputs_off: assert property (
    !enSync |=> (hsOn == HBF_ALL_CLEAR) && (lsOn == HBF_ALL_CLEAR) && sleepMode)
    else $error("outputs driven while enable low");

  a_warn_keeps_drive: assert property (
    enSync && mode == HBF_RUN && heatLatch == HBF_HEAT_CLEAR && ulCutoff == HBF_ALL_CLEAR
    |=> (hsOn | lsOn) == $past(drvEn))
    else $error("output dropped without shutdown cause");

  a_clear_single_pulse: assert property (
    clearPulse |=> !clearPulse)
    else $error("status clear held longer than one cycle");

  a_clear_after_frame: assert property (
    clearPulse |-> $past(csHigh) && $past(cmdPending, 2))
    else $error("status clear acted inside a frame");

  a_clear_group_scope: assert property (
    (clrMask != HBF_ALL_CLEAR) && !ulExpire && enSync
    |=> ((ulFault & $past(clrMask)) == HBF_ALL_CLEAR)
        && ((ulFault & ~$past(clrMask)) == ($past(ulFault) & ~$past(clrMask))))
    else $error("status clear scope wrong");

  a_ul_qualify: assert property (
    ulExpire && enSync |=> (ulFault & $past(ulEligible)) == $past(ulEligible))
    else $error("under-load not qualified at timer expiry");

  a_timer_runs: assert property (
    anyUl && (ulTimer != UL_LAST) |=> ulTimer == $past(ulTimer) + UL_ONE)
    else $error("shared timer stalled under persistent under-load");

  a_cutoff_armed: assert property (
    ulExpire && enSync && (clrMask == HBF_ALL_CLEAR)
    |=> ulCutoff == ($past(ulCutoff) | ($past(ulEligible) & $past(cutArm))))
    else $error("armed cutoff not latched");

  a_latch_holds: assert property (
    enSync && (clrMask == HBF_ALL_CLEAR) && !ulExpire
    |=> (ulFault == $past(ulFault)) && (ulCutoff == $past(ulCutoff)))
    else $error("latched fault changed without cause");

  a_discharge_follow: assert property (
    dischSync [*2] |-> dischargeOn)
    else $error("discharge path not on above threshold");

  c_status_clear: cover property (clearPulse ##1 !clearPulse);
  c_ul_cutoff: cover property (ulExpire && (ulEligible & cutArm) != HBF_ALL_CLEAR);
  c_sleep_wake: cover property (mode == HBF_SLEEP ##1 mode == HBF_RUN);

endmodule // hbf_fault_status

`default_nettype wire

// ---- src/hbf_pkg.sv ----
// constants and carrier types for the half-bridge fault and status logic
package hbf_pkg;

  localparam int HBF_CHANNELS = 10;
  localparam int HBF_GROUP_WIDTH = 6;
  localparam int HBF_UPPER_BASE = 6;
  localparam int HBF_UPPER_COUNT = 4;
  localparam int HBF_FRAME_BITS = 16;
  localparam logic [3:0] HBF_FRAME_LAST = 4'hF;

  // clock period and open-load qualify delay
  localparam int HBF_CLK_PERIOD_PS = 4000;
  localparam int HBF_UL_DELAY_US = 200;
  localparam int HBF_UL_DELAY_CYCLES = (HBF_UL_DELAY_US * 1000000) / HBF_CLK_PERIOD_PS;

  // channel groups: lower six bridges, upper four bridges
  localparam logic [9:0] HBF_GROUP0_MASK = 10'h03F;
  localparam logic [9:0] HBF_GROUP1_MASK = 10'h3C0;
  localparam logic [9:0] HBF_ALL_CLEAR = 10'h000;
  localparam logic [15:0] HBF_STATUS_RESET = 16'h0000;
  localparam logic [1:0] HBF_HEAT_CLEAR = 2'h0;

  // command word shifted in on the serial link
  typedef struct packed {
    logic statusClear;
    logic channelGroupSelect;
    logic underloadCutoffArm;
    logic spare;
    logic [5:0] bridgeConfig;
    logic [5:0] bridgeEnable;
  } hbf_cmd_type;

  // output status word shifted out on the serial link
  typedef struct packed {
    logic overCurrent;
    logic supplyFail;
    logic underloadFaultFlag;
    logic [1:0] reservedHigh;
    logic [3:0] bridgeActive;
    logic [1:0] reservedLow;
    logic [3:0] configReadback;
    logic heatWarningFlag;
  } hbf_status_type;

  typedef enum logic {HBF_SLEEP, HBF_RUN} hbf_mode_type;

endpackage

// ---- bench/hbf_spi_host.sv ----
// serial host model driving command frames and reading status
`timescale 1ns/1ps
`default_nettype none

module hbf_spi_host
  import hbf_pkg::*;
(
  output var logic sclk,
  output var logic spiSelect_n,
  output var logic mosi,
  input wire logic miso
);

  initial begin
    sclk = 1'b0;
    spiSelect_n = 1'b1;
    mosi = 1'b0;
  end

  // one 16-bit frame, msb first; clock idles low between frames
  // both high-side and low-side brake settings are sent by the bench
  task automatic xfer(input hbf_cmd_type cmd, output logic [15:0] st);
    logic [15:0] w;
    w = cmd;
    spiSelect_n = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      mosi = w[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
      st[i] = miso;
    end
    #5 spiSelect_n = 1'b1;
    mosi = ~mosi;
    #32;
  endtask

endmodule // hbf_spi_host

`default_nettype wire

// ---- bench/test_half_bridge_fault_status_logic.sv ----
// self-checking bench of the half-bridge fault and status logic
`timescale 1ns/1ps
`default_nettype none

module test_half_bridge_fault_status_logic
  import hbf_pkg::*;
;
  logic clk, arst_n, sclk, spiSelect_n, mosi, miso;
  logic enablePin, heatWarnPin, supplyOverDischarge, dischargeOn, sleepMode;
  logic [1:0] heatShutPin;
  logic [9:0] lsUnderCurrent, hsOn, lsOn;
  logic [15:0] st;
  int fails = 0;
  int cmp_count = 0;

  hbf_fault_status #(.UL_DELAY(16)) hbf_fault_status_inst (
    .clk(clk), .arst_n(arst_n), .sclk(sclk), .spiSelect_n(spiSelect_n),
    .mosi(mosi), .miso(miso), .enablePin(enablePin), .heatWarnPin(heatWarnPin),
    .heatShutPin(heatShutPin), .supplyOverDischarge(supplyOverDischarge),
    .lsUnderCurrent(lsUnderCurrent), .hsOn(hsOn), .lsOn(lsOn),
    .dischargeOn(dischargeOn), .sleepMode(sleepMode));

  hbf_spi_host hbf_spi_host_inst (
    .sclk(sclk), .spiSelect_n(spiSelect_n), .mosi(mosi), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wclk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic hbf_cmd_type g1(input logic clr, input logic arm);
    g1 = '{clr, 1'b1, arm, 1'b0, 6'h05, 6'h0F};
  endfunction

  task automatic send(input hbf_cmd_type c);
    hbf_spi_host_inst.xfer(c, st);
    wclk(1);
  endtask

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    enablePin = 1'b1;
    heatWarnPin = 1'b0;
    heatShutPin = 2'h0;
    supplyOverDischarge = 1'b0;
    lsUnderCurrent = 10'h000;
    wclk(5);
    arst_n = 1'b1;
    wclk(4);
    send(g1(1'b0, 1'b1));
    chk({6'h00, hsOn}, 16'h0140);
    chk({6'h00, lsOn}, 16'h0280);
    send(g1(1'b0, 1'b1));
    chk(st, 16'h078A);
    heatWarnPin = 1'b1;
    wclk(4);
    send(g1(1'b0, 1'b1));
    chk(st, 16'h078B);
    chk({6'h00, hsOn}, 16'h0140);
    heatWarnPin = 1'b0;
    wclk(4);
    send(g1(1'b0, 1'b1));
    chk(st, 16'h078A);
    lsUnderCurrent = 10'h080;
    wclk(10);
    chk({6'h00, lsOn}, 16'h0280);
    lsUnderCurrent = 10'h280;
    wclk(14);
    chk({6'h00, lsOn}, 16'h0000);
    send(g1(1'b0, 1'b1));
    chk(st & 16'h2000, 16'h2000);
    send('{1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 6'h00});
    chk({6'h00, lsOn}, 16'h0000);
    send(g1(1'b1, 1'b1));
    chk({6'h00, lsOn}, 16'h0280);
    wclk(30);
    chk({6'h00, lsOn}, 16'h0000);
    lsUnderCurrent = 10'h000;
    wclk(4);
    send(g1(1'b1, 1'b0));
    chk({6'h00, lsOn}, 16'h0280);
    send(g1(1'b0, 1'b0));
    chk(st & 16'h2000, 16'h0000);
    lsUnderCurrent = 10'h040;
    wclk(30);
    send(g1(1'b0, 1'b0));
    chk(st & 16'h2000, 16'h0000);
    lsUnderCurrent = 10'h080;
    wclk(30);
    chk({6'h00, lsOn}, 16'h0280);
    send(g1(1'b0, 1'b0));
    chk(st & 16'h2000, 16'h2000);
    enablePin = 1'b0;
    wclk(5);
    chk({15'h0000, sleepMode}, 16'h0001);
    chk({6'h00, hsOn | lsOn}, 16'h0000);
    enablePin = 1'b1;
    lsUnderCurrent = 10'h000;
    wclk(5);
    chk({15'h0000, sleepMode}, 16'h0000);
    send(g1(1'b0, 1'b0));
    send(g1(1'b0, 1'b0));
    chk(st, 16'h078A);
    chk({6'h00, hsOn}, 16'h0140);
    heatShutPin = 2'h2;
    wclk(5);
    chk({6'h00, hsOn | lsOn}, 16'h0000);
    heatShutPin = 2'h0;
    send(g1(1'b1, 1'b0));
    chk({6'h00, hsOn}, 16'h0140);
    arst_n = 1'b0;
    wclk(2);
    chk({15'h0000, sleepMode}, 16'h0001);
    chk({6'h00, hsOn | lsOn}, 16'h0000);
    arst_n = 1'b1;
    wclk(5);
    send(g1(1'b0, 1'b0));
    chk({6'h00, hsOn}, 16'h0140);
    supplyOverDischarge = 1'b1;
    wclk(4);
    chk({15'h0000, dischargeOn}, 16'h0001);
    supplyOverDischarge = 1'b0;
    wclk(4);
    chk({15'h0000, dischargeOn}, 16'h0000);
    summarize();
  end

endmodule // test_half_bridge_fault_status_logic

`default_nettype wire
